/* common/srt_pkg.sv */
// Purpose: Shared constants and types of the six channel reload timer.
// Assumes: Byte addressed register port, 16-bit data lane.
// Notes:   Byte registers sit in the low eight bits of the data lane.

// ==================================================
// Package
package srt_pkg;
  // Address and data widths of the register port, and channel count
  localparam int SRT_AW = 10;
  localparam int SRT_DW = 16;
  localparam int SRT_NCH = 6;

  // Global byte registers
  localparam logic [9:0] SRT_PCS_OFS = 10'h012;
  localparam logic [9:0] SRT_PRST_OFS = 10'h015;
  localparam logic [9:0] SRT_PROT_OFS = 10'h00a;
  localparam logic [9:0] SRT_CLS_LO_OFS = 10'h1c6;
  localparam logic [9:0] SRT_CLS_HI_OFS = 10'h1e6;
  localparam logic [9:0] SRT_PDIV_OFS = 10'h1cb;
  localparam logic [9:0] SRT_UPST_OFS = 10'h300;
  localparam logic [9:0] SRT_SHST_OFS = 10'h320;

  // Per channel offsets, channel 0 first
  localparam logic [9:0] SRT_CNT_OFS [6] = '{10'h330, 10'h332, 10'h334,
                                             10'h310, 10'h312, 10'h314};
  localparam logic [9:0] SRT_MODE_OFS [6] = '{10'h33b, 10'h33c, 10'h33d,
                                              10'h31b, 10'h31c, 10'h31d};
  localparam logic [9:0] SRT_SEC_OFS [6] = '{10'h1c0, 10'h1c2, 10'h1c4,
                                             10'h1e0, 10'h1e2, 10'h1e4};
  localparam logic [9:0] SRT_SRC_OFS [6] = '{10'h1c8, 10'h1c8, 10'h1c9,
                                             10'h1e8, 10'h1e8, 10'h1e9};
  // Low bit of each source field inside its register
  localparam int SRT_SRC_POS [6] = '{0, 4, 0, 0, 4, 0};
  // Channel whose underflow feeds each channel in event mode
  localparam int SRT_CHAIN [6] = '{2, 0, 1, 5, 3, 4};

  // Field positions
  localparam int SRT_START_POS = 5;
  localparam int SRT_PRST_BIT = 7;
  localparam int SRT_PDIV_BIT = 1;
  localparam int SRT_HALF_BIT = 0;
  localparam int SRT_UNLOCK_BIT = 0;

  // Reset values and counter maximum
  localparam logic [7:0] SRT_PCS_RST = 8'h03;
  localparam logic [7:0] SRT_SHST_RST = 8'h00;
  localparam logic [2:0] SRT_SRC_RST = 3'h0;
  localparam logic [15:0] SRT_CNT_RST = 16'h0000;
  localparam logic [15:0] SRT_CNT_MAX = 16'hffff;

  // Operating modes
  typedef enum logic [1:0] {
    SRT_TIMER = 2'b00,
    SRT_EVENT = 2'b01,
    SRT_MEAS = 2'b10,
    SRT_BAD = 2'b11
  } srt_op_type;

  // Writable part of a channel mode register
  typedef struct packed {
    logic [1:0] tck;
    logic [1:0] pol;
    srt_op_type op;
  } srt_mode_cfg_type;

  localparam srt_mode_cfg_type SRT_MODE_RST = '{2'h0, 2'h0, SRT_TIMER};
endpackage : srt_pkg

/* hdl/srt_channel.sv */
// Purpose: One 16-bit reload timer channel.
// Assumes: All inputs synchronous to clk; tick is a one-cycle enable.
// Notes:   Count, reload and overflow state live here; decode is in the top.

`timescale 1ns/10ps

// ==================================================
// Channel
module srt_channel
  import srt_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic start,
  input srt_mode_cfg_type cfg,
  input wire logic pin,
  input wire logic chain_ev,
  input wire logic cnt_wr,
  input wire logic [15:0] wr_data,
  input wire logic ovf_clr,
  output logic [15:0] count_q,
  output logic [15:0] reload_q,
  output logic ovf_q,
  output logic irq_q,
  output logic uf_q
);
  logic pin_q;      // Previous pin level
  logic armed_q;    // First measured edge seen
  logic ticked_q;   // First count step seen since start
  logic rise;
  logic fall;
  logic meas_edge;
  logic ev_edge;
  logic step;
  logic is_meas;

  // ==================================================
  // Edge selection
  assign rise = pin & ~pin_q;
  assign fall = ~pin & pin_q;
  assign is_meas = (cfg.op == SRT_MEAS);

  // Period uses one polarity, width uses both edges
  always_comb begin
    case (cfg.pol)
      2'b00: meas_edge = fall;
      2'b01: meas_edge = rise;
      2'b10: meas_edge = rise | fall;
      default: meas_edge = 1'b0;
    endcase
  end

  // Event source: pin edges or a neighbour underflow
  always_comb begin
    if (cfg.tck[1]) begin
      ev_edge = chain_ev;
    end else begin
      case (cfg.pol)
        2'b00: ev_edge = fall;
        2'b01: ev_edge = rise;
        2'b10: ev_edge = rise | fall;
        default: ev_edge = 1'b0;
      endcase
    end
  end

  // Count step: event source in event mode, else the selected source; code 11 never steps
  assign step = (cfg.op == SRT_EVENT) ? ev_edge
                : (tick & (cfg.op != SRT_BAD));

  // ==================================================
  // Counter state
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_q <= 1'b0;
      armed_q <= 1'b0;
      ticked_q <= 1'b0;
      count_q <= SRT_CNT_RST;
      reload_q <= SRT_CNT_RST;
      ovf_q <= 1'b0;
      irq_q <= 1'b0;
      uf_q <= 1'b0;
    end else begin
      pin_q <= pin;
      irq_q <= 1'b0;
      uf_q <= 1'b0;
      // Clear first so a same-cycle overflow keeps the flag
      if (ovf_clr) begin
        ovf_q <= 1'b0;
      end
      // Stopping forgets progress but keeps the values
      if (!start) begin
        armed_q <= 1'b0;
        ticked_q <= 1'b0;
      end
      if (is_meas) begin
        if (start && meas_edge) begin
          // Edge restarts from zero, second edge captures
          armed_q <= 1'b1;
          count_q <= SRT_CNT_RST;
          if (armed_q) begin
            reload_q <= count_q;
            irq_q <= 1'b1;
          end
        end else if (start && armed_q && tick) begin
          count_q <= count_q + 16'h0001;
          if (count_q == SRT_CNT_MAX) begin
            ovf_q <= 1'b1;
            irq_q <= 1'b1;
          end
        end else if (!start && cnt_wr) begin
          // Writes while running are dropped
          count_q <= wr_data;
          reload_q <= wr_data;
        end
      end else begin
        if (start && step) begin
          ticked_q <= 1'b1;
          if (count_q == SRT_CNT_RST) begin
            count_q <= reload_q;
            uf_q <= 1'b1;
            irq_q <= 1'b1;
          end else begin
            count_q <= count_q - 16'h0001;
          end
        end
        if (cnt_wr) begin
          reload_q <= wr_data;
          // After the first step only the reload takes it
          if (!(start && ticked_q)) begin
            count_q <= wr_data;
          end
        end
      end
    end
  end
endmodule : srt_channel

/* hdl/srt_top.sv */
// Purpose: Six channel 16-bit reload timer with its register file.
// Assumes: Register port strobes are one cycle and never overlap.
// Notes:   Read data appear in the cycle after the read strobe only.
//
// Chosen here: the strobed register port.

`timescale 1ns/10ps

// ==================================================
// Top
// Contract
// - six independent 16-bit channels
// - timer, event and pulse measurement modes
// - two-bit field selects channel mode
// - each channel raises its own request
// - pin feeds events and measured pulse
// - running measurement ignores counter writes
// - edge starts count, next edge captures
// - select zero: counter reads result
// - select one: live count, secondary result
// - capture select acts in measurement only
// - source register holds two 3-bit fields
// - half-rate bit picks undivided or halved
// - mode bit four unimplemented, reads zero
// - selected source steps the channel
// - down count reloads after reaching zero
// - early write loads counter and reload
// - later write loads reload only
// - start bits five to seven, two registers
// - overflow sets flag and raises request
module srt_top
  import srt_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  input wire logic [5:0] channel_event_input,
  input wire logic [2:0] aux_tick,
  output logic [5:0] irq_req
);

  // ==================================================
  // Declarations
  logic [7:0] pcs_q;        // Peripheral clock select
  logic unlock_q;           // Protection unlock bit
  logic pdiv_q;             // Pre-divider choice
  logic [7:0] shst_q;       // Shared start flags
  logic [2:0] upst_q;       // Upper start flags, bits 7:5
  logic [2:0] cls_lo_q;     // Capture select, channels 0 to 2
  logic [2:0] cls_hi_q;     // Capture select, channels 3 to 5
  logic [5:0] div_q;        // Shared prescaler
  logic [15:0] rd_q;        // Registered read data
  logic [15:0] rd_d;        // Read mux result
  logic [2:0] src_q [6];    // Source field per channel
  srt_mode_cfg_type mode_q [6];
  logic base_tick;          // Prescaler input enable
  logic [7:0] tk;           // Tick per source code
  logic prst_wr;            // Prescaler reset strobe
  logic [5:0] start;
  logic [5:0] cls;
  logic [5:0] ch_tick;
  logic [5:0] cnt_wr;
  logic [5:0] mode_wr;
  logic [5:0] src_wr;
  logic [5:0] ovf;
  logic [5:0] uf;
  logic [5:0] irq;
  logic [15:0] cnt [6];
  logic [15:0] rel [6];

  // ==================================================
  // Helpers

  // Byte-register write hit
  function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Bit ch of a per-channel start or select view
  function automatic logic pick(input logic [2:0] lo,
                                input logic [2:0] hi, input int ch);
    if (ch < 3) begin
      pick = lo[ch];
    end else begin
      pick = hi[ch - 3];
    end
  endfunction : pick

  // ==================================================
  // Prescaler
  // Base is the system clock or the first aux tick
  assign base_tick = pdiv_q ? aux_tick[0] : 1'b1;

  // Divided ticks come from one shared counter so phases line up
  assign tk[0] = pcs_q[SRT_HALF_BIT] ? base_tick
                 : (base_tick & div_q[0]);
  assign tk[1] = base_tick & (&div_q[2:0]);
  assign tk[2] = base_tick & (&div_q[4:0]);
  assign tk[3] = base_tick & (&div_q);
  assign tk[4] = aux_tick[0];
  assign tk[5] = aux_tick[1];
  assign tk[6] = aux_tick[2];
  // Code seven is unused and never ticks
  assign tk[7] = 1'b0;

  assign prst_wr = wr_en && hit(addr, SRT_PRST_OFS)
                   && wr_data[SRT_PRST_BIT];

  // Free running divider, restarted by the reset flag
  always_ff @(posedge clk) begin
    if (reset || prst_wr) begin
      div_q <= 6'h00;
    end else if (base_tick) begin
      div_q <= div_q + 6'h01;
    end
  end

  // ==================================================
  // Global register writes
  // Clock select is locked unless the unlock bit is set
  always_ff @(posedge clk) begin
    if (reset) begin
      pcs_q <= SRT_PCS_RST;
      unlock_q <= 1'b0;
      pdiv_q <= 1'b0;
      shst_q <= SRT_SHST_RST;
      upst_q <= 3'h0;
      cls_lo_q <= 3'h0;
      cls_hi_q <= 3'h0;
    end else if (wr_en) begin
      if (hit(addr, SRT_PROT_OFS)) begin
        unlock_q <= wr_data[SRT_UNLOCK_BIT];
      end
      if (hit(addr, SRT_PCS_OFS) && unlock_q) begin
        pcs_q <= wr_data[7:0];
      end
      if (hit(addr, SRT_PDIV_OFS)) begin
        pdiv_q <= wr_data[SRT_PDIV_BIT];
      end
      if (hit(addr, SRT_SHST_OFS)) begin
        shst_q <= wr_data[7:0];
      end
      if (hit(addr, SRT_UPST_OFS)) begin
        upst_q <= wr_data[7:5];
      end
      if (hit(addr, SRT_CLS_LO_OFS)) begin
        cls_lo_q <= wr_data[2:0];
      end
      if (hit(addr, SRT_CLS_HI_OFS)) begin
        cls_hi_q <= wr_data[2:0];
      end
    end
  end

  // ==================================================
  // Channels
  genvar g;
  generate
    for (g = 0; g < SRT_NCH; g++) begin : g_ch
      // Start and capture select of this channel
      assign start[g] = pick(shst_q[7:5], upst_q, g);
      assign cls[g] = pick(cls_lo_q, cls_hi_q, g);

      // Counter word writes at the even address only; mode and source are byte writes
      assign cnt_wr[g] = wr_en && hit(addr, SRT_CNT_OFS[g]);
      assign mode_wr[g] = wr_en && hit(addr, SRT_MODE_OFS[g]);
      assign src_wr[g] = wr_en && hit(addr, SRT_SRC_OFS[g]);

      // Source code picks one prescaler tick
      assign ch_tick[g] = tk[src_q[g]];

      // Source field and mode register of this channel
      always_ff @(posedge clk) begin
        if (reset) begin
          src_q[g] <= SRT_SRC_RST;
          mode_q[g] <= SRT_MODE_RST;
        end else begin
          if (src_wr[g]) begin
            src_q[g] <= wr_data[SRT_SRC_POS[g] +: 3];
          end
          if (mode_wr[g]) begin
            // Bits 5 and 4 are not stored
            mode_q[g] <= {wr_data[7:6], wr_data[3:2],
                          srt_op_type'(wr_data[1:0])};
          end
        end
      end

      // Each channel runs alone apart from the event chain
      srt_channel u_ch (
        .clk(clk),
        .reset(reset),
        .tick(ch_tick[g]),
        .start(start[g]),
        .cfg(mode_q[g]),
        .pin(channel_event_input[g]),
        .chain_ev(uf[SRT_CHAIN[g]]),
        .cnt_wr(cnt_wr[g]),
        .wr_data(wr_data),
        .ovf_clr(mode_wr[g]),
        .count_q(cnt[g]),
        .reload_q(rel[g]),
        .ovf_q(ovf[g]),
        .irq_q(irq[g]),
        .uf_q(uf[g])
      );
    end
  endgenerate

  // ==================================================
  // Read mux
  // Fields that share one byte address are OR-ed together
  always_comb begin
    rd_d = 16'h0000;
    if (hit(addr, SRT_PCS_OFS)) begin
      rd_d[7:0] = pcs_q;
    end
    if (hit(addr, SRT_PROT_OFS)) begin
      rd_d[SRT_UNLOCK_BIT] = unlock_q;
    end
    if (hit(addr, SRT_PDIV_OFS)) begin
      rd_d[SRT_PDIV_BIT] = pdiv_q;
    end
    if (hit(addr, SRT_SHST_OFS)) begin
      rd_d[7:0] = shst_q;
    end
    if (hit(addr, SRT_UPST_OFS)) begin
      rd_d[7:5] = upst_q;
    end
    if (hit(addr, SRT_CLS_LO_OFS)) begin
      rd_d[2:0] = cls_lo_q;
    end
    if (hit(addr, SRT_CLS_HI_OFS)) begin
      rd_d[2:0] = cls_hi_q;
    end
    for (int i = 0; i < SRT_NCH; i++) begin
      if (hit(addr, SRT_SRC_OFS[i])) begin
        rd_d[SRT_SRC_POS[i] +: 3] = src_q[i];
      end
      if (hit(addr, SRT_MODE_OFS[i])) begin
        // Bit 4 has no storage and reads zero
        rd_d[7:0] = {mode_q[i].tck, ovf[i], 1'b0,
                     mode_q[i].pol, mode_q[i].op};
      end
      if (hit(addr, SRT_CNT_OFS[i])) begin
        // Capture select matters only in measurement mode
        if (mode_q[i].op == SRT_MEAS && !cls[i]) begin
          rd_d = rel[i];
        end else begin
          rd_d = cnt[i];
        end
      end
      if (hit(addr, SRT_SEC_OFS[i])) begin
        // Undefined when unused; zero is a safe choice
        if (mode_q[i].op == SRT_MEAS && cls[i]) begin
          rd_d = rel[i];
        end
      end
    end
  end

  // ==================================================
  // Read data register
  // Data stand for one cycle only, zero otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_q <= 16'h0000;
    end else if (rd_en) begin
      rd_q <= rd_d;
    end else begin
      rd_q <= 16'h0000;
    end
  end

  // ==================================================
  // Outputs
  // Both come straight from flip-flops
  assign rd_data = rd_q;
  assign irq_req = irq;
endmodule : srt_top

/* verif/srt_chk.sv */
// Purpose: Port-level assertions for the six channel reload timer.
// Assumes: Sees only top ports; shadows a few registers from the writes.
// Notes:   Shadows cover start flags, unlock and the half-rate bit only.

`timescale 1ns/10ps

// ==================================================
// Checker
module srt_chk
  import srt_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rd_data,
  input wire logic [5:0] channel_event_input,
  input wire logic [2:0] aux_tick,
  input wire logic [5:0] irq_req
);
  logic [7:0] shst_q; // Shared start flags shadow
  logic [2:0] ust_q; // Upper start bits shadow
  logic unlock_q; // Clock write unlock shadow
  logic half_q; // Half-rate choice shadow
  wire logic [5:0] run_w = {ust_q, shst_q[7:5]}; // Per channel start bits
  // Mode registers of both channel groups
  wire logic mode_hit = (addr[9:4] == 6'h33 || addr[9:4] == 6'h31) &&
                        (addr[3:0] inside {4'hb, 4'hc, 4'hd});

  // Shadow follows accepted writes only
  always_ff @(posedge clk) begin
    if (reset) begin
      shst_q <= SRT_SHST_RST;
      ust_q <= 3'h0;
      unlock_q <= 1'b0;
      half_q <= SRT_PCS_RST[0];
    end else if (wr_en) begin
      if (addr == SRT_SHST_OFS) shst_q <= wr_data[7:0];
      if (addr == SRT_UPST_OFS) ust_q <= wr_data[7:5];
      if (addr == SRT_PROT_OFS) unlock_q <= wr_data[0];
      // A locked write leaves the clock choice alone
      if (addr == SRT_PCS_OFS && unlock_q) half_q <= wr_data[0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_rd(a);
    rd_en && addr == a;
  endsequence

  property p_rd_quiet;
    !rd_en |=> rd_data == 16'h0000;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not zero when idle");
  property p_odd;
    s_rd(SRT_CNT_OFS[0] + 10'h001) |=> rd_data == 16'h0000;
  endproperty
  a_odd: assert property (p_odd) else $error("odd counter byte not zero");
  property p_mode_b4;
    rd_en && mode_hit |=> rd_data[15:8] == 8'h00 && !rd_data[4];
  endproperty
  a_mode_b4: assert property (p_mode_b4) else $error("mode bit four not zero");
  property p_shst;
    s_rd(SRT_SHST_OFS) |=> rd_data == {8'h00, $past(shst_q)};
  endproperty
  a_shst: assert property (p_shst) else $error("shared start flags mismatch");
  property p_upst;
    s_rd(SRT_UPST_OFS) |=> rd_data[15:5] == {8'h00, $past(ust_q)};
  endproperty
  a_upst: assert property (p_upst) else $error("upper start flags mismatch");
  property p_pcs_lock;
    s_rd(SRT_PCS_OFS) |=> rd_data[0] == $past(half_q) && rd_data[15:8] == 8'h00;
  endproperty
  a_pcs_lock: assert property (p_pcs_lock) else $error("clock select lock broken");
  property p_unmapped;
    s_rd(10'h3ff) |=> rd_data == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reset_quiet;
    $fell(reset) |-> irq_req == 6'h00 && rd_data == 16'h0000;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  // A request needs the channel started one or two cycles earlier
  property p_irq_run;
    |irq_req |-> (irq_req & ~($past(run_w) | $past(run_w, 2))) == 6'h00;
  endproperty
  a_irq_run: assert property (p_irq_run) else $error("request from stopped channel");
endmodule : srt_chk

bind srt_top srt_chk chk_u (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .channel_event_input(channel_event_input),
  .aux_tick(aux_tick), .irq_req(irq_req));

/* verif/srt_pulse_model.sv */
// Purpose: External pulse source on the channel event pins.
// Assumes: Period of at least three cycles; one channel at a time.
// Notes:   Count 8'hff runs until the next go; pins idle low.

`timescale 1ns/10ps

// ==================================================
// Pulse source
module srt_pulse_model
  import srt_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [2:0] ch,
  input wire logic [15:0] period,
  input wire logic [7:0] count,
  output logic busy,
  output logic [5:0] channel_event_input
);
  logic [15:0] gap_q; // Cycles to the next rising edge
  logic [15:0] per_q; // Spacing of rising edges
  logic [7:0] left_q; // Pulses still to send
  logic [2:0] ch_q; // Channel being driven
  wire logic hi_w = left_q != 8'h00 && gap_q == per_q; // One-cycle high pulse

  // A new go replaces any burst in progress
  always_ff @(posedge clk) begin
    if (reset) begin
      left_q <= 8'h00;
      gap_q <= 16'h0000;
      per_q <= 16'h0000;
      ch_q <= 3'h0;
    end else if (go) begin
      left_q <= count;
      gap_q <= period;
      per_q <= period;
      ch_q <= ch;
    end else if (left_q != 8'h00) begin
      if (gap_q == 16'h0001) begin
        gap_q <= per_q;
        if (left_q != 8'hff) left_q <= left_q - 8'h01;
      end else begin
        gap_q <= gap_q - 16'h0001;
      end
    end
  end
  assign busy = left_q != 8'h00;
  assign channel_event_input = hi_w ? 6'(1 << ch_q) : 6'h00;
endmodule : srt_pulse_model

/* verif/srt_top_bench.sv */
// Purpose: Self-checking bench for the six channel reload timer.
// Assumes: Half-rate bit at 1 so source code 0 steps every clock.
// Notes:   Periods are measured on a free cycle counter.

`timescale 1ns/10ps

// ==================================================
// Bench
module srt_top_bench
  import srt_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] addr = 10'h000;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rd_data;
  logic [5:0] pins; // Pins from the pulse source
  logic go = 1'b0;
  logic [2:0] p_ch = 3'h0;
  logic [15:0] p_per = 16'h0000;
  logic [7:0] p_cnt = 8'h00;
  logic p_busy;
  logic [5:0] irq_req;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0; // Free running cycle count

  srt_top dut_u (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .channel_event_input(pins), .aux_tick(3'h0),
    .irq_req(irq_req));
  srt_pulse_model src_u (.clk(clk), .reset(reset), .go(go), .ch(p_ch), .period(p_per),
    .count(p_cnt), .busy(p_busy), .channel_event_input(pins));

  // Clock and cycle counter
  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // ==================================================
  // Shared tasks
  task automatic end_of_test();
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, output logic [15:0] v);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask : rd
  task automatic pulse(input logic [2:0] c, input logic [15:0] p, input logic [7:0] n);
    @(posedge clk);
    go <= 1'b1;
    p_ch <= c;
    p_per <= p;
    p_cnt <= n;
    @(posedge clk);
    go <= 1'b0;
  endtask : pulse
  // Returns the cycle of the request, 0 when none came within the bound
  task automatic wait_irq(input int c, input int bound, input bit exp, output int t);
    t = 0;
    for (int i = 0; i < bound; i++) begin
      @(posedge clk);
      #1;
      if (irq_req[c] === 1'b1) begin
        t = cyc;
        break;
      end
    end
    if (exp != (t != 0)) begin
      $display("[ERR] irq_req[%0d] expected %0d seen %0d", c, exp, t != 0);
      num_errors++;
      if (exp) end_of_test();
    end
  endtask : wait_irq

  // ==================================================
  // Scenarios
  task automatic t_reset_vals();
    logic [15:0] v;
    rd(SRT_PCS_OFS, v);
    chk("clock select", 16'h0003, v);
    rd(SRT_SHST_OFS, v);
    chk("shared start", 16'h0000, v);
    rd(SRT_SRC_OFS[0], v);
    chk("source 0", 16'h0000, v);
    rd(SRT_MODE_OFS[0], v);
    chk("mode 0", 16'h0000, v & 16'hffcf);
  endtask : t_reset_vals
  task automatic t_timer();
    logic [15:0] v;
    logic [15:0] w;
    int t0, t1, t2, t3;
    wr(SRT_CNT_OFS[0], 16'h0005);
    rd(SRT_CNT_OFS[0], v);
    chk("cnt0 stopped", 16'h0005, v);
    wr(SRT_SHST_OFS, 16'h0020);
    wait_irq(0, 100, 1, t0);
    wait_irq(0, 100, 1, t1);
    chk("period n5", 16'd6, 16'(t1 - t0));
    wr(SRT_CNT_OFS[0], 16'h0009);
    wait_irq(0, 100, 1, t2);
    wait_irq(0, 100, 1, t3);
    chk("period old", 16'd6, 16'(t2 - t1));
    chk("period new", 16'd10, 16'(t3 - t2));
    wr(SRT_SHST_OFS, 16'h0000);
    rd(SRT_CNT_OFS[0], v);
    rd(SRT_CNT_OFS[0], w);
    chk("cnt0 held", v, w);
    wait_irq(0, 30, 0, t0);
  endtask : t_timer
  task automatic t_event();
    logic [15:0] v;
    int t;
    wr(SRT_MODE_OFS[3], 16'h0005);
    wr(SRT_CNT_OFS[3], 16'h0001);
    wr(SRT_UPST_OFS, 16'h0020);
    pulse(3'h3, 16'd10, 8'h01);
    wait_irq(3, 40, 0, t);
    rd(SRT_CNT_OFS[3], v);
    chk("cnt3 one event", 16'h0000, v);
    pulse(3'h3, 16'd10, 8'h01);
    wait_irq(3, 40, 1, t);
    wr(SRT_UPST_OFS, 16'h0000);
  endtask : t_event
  task automatic t_meas();
    logic [15:0] r1, r2, a, b;
    int t;
    wr(SRT_MODE_OFS[1], 16'h0006);
    wr(SRT_CLS_LO_OFS, 16'h0002);
    wr(SRT_SHST_OFS, 16'h0040);
    pulse(3'h1, 16'd20, 8'h03);
    wait_irq(1, 100, 1, t);
    rd(SRT_SEC_OFS[1], r1);
    pulse(3'h1, 16'd40, 8'hff);
    wait_irq(1, 100, 1, t);
    wait_irq(1, 100, 1, t);
    rd(SRT_SEC_OFS[1], r2);
    chk("capture step", 16'd20, r2 - r1);
    rd(SRT_CNT_OFS[1], a);
    rd(SRT_CNT_OFS[1], b);
    chk("live count", 16'd2, b - a);
    wr(SRT_CNT_OFS[1], 16'h1234);
    rd(SRT_CNT_OFS[1], a);
    chk("write ignored", 16'h0001, {15'h0, a < 16'd100});
    wr(SRT_CLS_LO_OFS, 16'h0000);
    wait_irq(1, 100, 1, t);
    rd(SRT_CNT_OFS[1], a);
    rd(SRT_CNT_OFS[1], b);
    chk("result held a", r2, a);
    chk("result held b", r2, b);
    pulse(3'h1, 16'd40, 8'h00);
    wait_irq(1, 70000, 1, t);
    rd(SRT_MODE_OFS[1], a);
    chk("overflow flag", 16'h0026, a & 16'h003f);
    wr(SRT_SHST_OFS, 16'h0000);
    wr(SRT_MODE_OFS[1], 16'h0006);
    rd(SRT_MODE_OFS[1], a);
    chk("flag cleared", 16'h0006, a & 16'h003f);
  endtask : t_meas
  task automatic t_lock();
    logic [15:0] v;
    wr(SRT_PCS_OFS, 16'h0000);
    rd(SRT_PCS_OFS, v);
    chk("locked select", 16'h0001, v & 16'h0001);
    wr(SRT_PROT_OFS, 16'h0001);
    wr(SRT_PCS_OFS, 16'h0002);
    rd(SRT_PCS_OFS, v);
    chk("unlocked select", 16'h0000, v & 16'h0001);
    wr(SRT_SRC_OFS[0], 16'h0035);
    rd(SRT_SRC_OFS[0], v);
    chk("source fields", 16'h0035, v & 16'h0077);
    rd(SRT_CNT_OFS[0] + 10'h001, v);
    chk("odd byte", 16'h0000, v);
    rd(10'h3ff, v);
    chk("unmapped", 16'h0000, v);
  endtask : t_lock

  // ==================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    wr(SRT_PDIV_OFS, 16'h0000);
    t_reset_vals();
    t_timer();
    t_event();
    t_meas();
    t_lock();
    end_of_test();
  end
endmodule : srt_top_bench
